// [scc_pkg.sv]
/*
 Shared constants for the sensor control channel link: sensor register
 map, receiver register map, status word layout and timing counts.
 Assumes both ends run on one 10 MHz sys_clk.
*/
package scc_pkg;
  // sensor register byte addresses
  localparam logic [6:0] SR_ROWS_LO = 7'h01;
  localparam logic [6:0] SR_ROWS_HI = 7'h02;
  localparam logic [6:0] SR_EXP_SRC = 7'h29;
  localparam logic [6:0] SR_EXP_LO = 7'h2a;
  localparam logic [6:0] SR_EXP_HI = 7'h2b;
  localparam logic [6:0] SR_OUT_MODE = 7'h48;
  localparam logic [6:0] SR_OVH_LEN = 7'h49;
  localparam logic [6:0] SR_TRAIN_LO = 7'h4e;
  localparam logic [6:0] SR_TRAIN_HI = 7'h4f;
  localparam logic [6:0] SR_PIN_A_SEL = 7'h6c;
  localparam logic [6:0] SR_PIN_B_SEL = 7'h6d;
  // out mode register fields
  localparam int OM_OUTS_LSB = 0;
  localparam int OM_WIDE_BIT = 2;
  // sensor register reset values
  localparam logic [15:0] ROWS_RST = 16'h0800;
  localparam logic [15:0] EXP_LEN_RST = 16'h0800;
  localparam logic [7:0] OVH_LEN_RST = 8'h0a;
  localparam logic [11:0] TRAIN_RST = 12'h3a5;
  // status word bit positions
  localparam int CW_PIX = 0;
  localparam int CW_ROW = 1;
  localparam int CW_FRAME = 2;
  localparam int CW_BURST_OH = 3;
  localparam int CW_LINE_OH = 4;
  localparam int CW_FOT = 5;
  localparam int CW_EXP_A = 6;
  localparam int CW_EXP_B = 7;
  localparam int CW_ONE = 9;
  localparam logic [11:0] CW_IDLE = 12'h200;
  // readout and exposure timing, in pixel periods
  localparam int BURST_PIX = 128;
  localparam int EXP_MULT = 129;
  localparam int OVH_NUM = 43;
  localparam int OVH_DEN = 100;
  // bit clock: 4 sys_clk per bit, low half then high half
  localparam int BIT_CYC = 4;
  localparam int WORD_NARROW = 10;
  localparam int WORD_WIDE = 12;
  localparam int DATA_LINES = 16;
  // host register word addresses
  localparam logic [3:0] HR_SENS_ADDR = 4'h0;
  localparam logic [3:0] HR_SENS_WR = 4'h1;
  localparam logic [3:0] HR_SENS_RD = 4'h2;
  localparam logic [3:0] HR_PULSE = 4'h3;
  localparam logic [3:0] HR_CFG = 4'h4;
  localparam logic [3:0] HR_STATUS = 4'h5;
  localparam logic [3:0] HR_PIX_CNT = 4'h6;
  localparam logic [3:0] HR_LAST_PIX = 4'h7;
  // exposure pins held this long so the 3-flop sampler sees them
  localparam logic [3:0] PIN_PULSE_CYC = 4'h8;
endpackage

// [scc_link_if.sv]
/*
 Link between the sensor end and the receiver end: serial lines, bit
 clock, exposure pins, status pins and the sensor register port.
 Assumes the register port runs on the sys_clk shared by both ends.
*/
`timescale 1ns/1ps
interface scc_link_if;
  logic link_clk;
  logic ctrl_line;
  logic [15:0] data_line;
  logic exposure_start_pin;
  logic readout_trigger_pin;
  logic status_pin_a;
  logic status_pin_b;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  modport sensor(output link_clk, ctrl_line, data_line, status_pin_a,
    status_pin_b, reg_rdata, input exposure_start_pin,
    readout_trigger_pin, reg_addr, reg_wdata, reg_wr, reg_rd);
  modport receiver(input link_clk, ctrl_line, data_line, status_pin_a,
    status_pin_b, reg_rdata, output exposure_start_pin,
    readout_trigger_pin, reg_addr, reg_wdata, reg_wr, reg_rd);
endinterface

// [scc_sync.sv]
/*
 Three-flop sampler for a signal from outside the sys_clk domain.
 A change is taken once the second and third stages agree.
*/
`timescale 1ns/1ps
module scc_sync (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // async reset
  input wire logic d, // asynchronous input
  output logic q // filtered level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule

// [scc_sensor.sv]
/*
 Sensor end: register file, exposure/readout sequencer, status word
 and 16 data serializers, bit clock made by division of sys_clk.
 Assumes sys_clk is the master clock; a pixel period is one word time.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module scc_sensor import scc_pkg::*; (
  input wire logic sys_clk, // master clock
  input wire logic arst_n, // async reset, active low
  scc_link_if.sensor lnk, // link to receiver
  output logic frame_busy // sequencer not idle
);
  typedef enum logic [1:0] {ST_IDLE, ST_EXPOSE, ST_FOT, ST_READ} scc_st_t;

  logic exp_src;
  logic [15:0] exp_len;
  logic [15:0] rows;
  logic [7:0] ovh_len;
  logic [11:0] train;
  logic [2:0] pin_a_sel;
  logic [2:0] pin_b_sel;
  logic [1:0] outs;
  logic wide;
  logic wide_l;
  logic start_lvl;
  logic trig_lvl;
  logic start_prev;
  logic trig_prev;
  logic start_pend;
  logic trig_pend;
  logic [1:0] bit_cnt;
  logic [3:0] bit_idx;
  logic bit_tick;
  logic pix_tick;
  scc_st_t st;
  logic [31:0] tcnt;
  logic [15:0] row;
  logic [2:0] burst;
  logic [7:0] col;
  logic [11:0] cword;
  logic [11:0] sh [DATA_LINES+1];

  // pixel period count of the frame overhead share: 129 * 0.43 * ovh
  function automatic logic [31:0] fot_cycles(input logic [7:0] ovh);
    logic [31:0] v;
    v = (32'(ovh) * 32'(EXP_MULT * OVH_NUM)) / 32'(OVH_DEN);
    return (v == 32'h0) ? 32'h1 : v;
  endfunction
  function automatic logic sel_bit(input logic [2:0] s,
                                   input logic [11:0] w);
    unique case (s)
      3'h0: sel_bit = w[CW_EXP_A];
      3'h1: sel_bit = w[CW_EXP_B];
      3'h2: sel_bit = w[CW_PIX];
      3'h3: sel_bit = w[CW_ROW];
      3'h4: sel_bit = w[CW_FRAME];
      default: sel_bit = 1'b0;
    endcase
  endfunction

  // register writes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      exp_src <= 1'b0;
      exp_len <= EXP_LEN_RST;
      rows <= ROWS_RST;
      ovh_len <= OVH_LEN_RST;
      train <= TRAIN_RST;
      pin_a_sel <= 3'h0;
      pin_b_sel <= 3'h0;
      outs <= 2'h0;
      wide <= 1'b0;
    end else if (lnk.reg_wr) begin
      case (lnk.reg_addr)
        SR_EXP_SRC: exp_src <= lnk.reg_wdata[0];
        SR_EXP_LO: exp_len[7:0] <= lnk.reg_wdata;
        SR_EXP_HI: exp_len[15:8] <= lnk.reg_wdata;
        SR_ROWS_LO: rows[7:0] <= lnk.reg_wdata;
        SR_ROWS_HI: rows[15:8] <= lnk.reg_wdata;
        SR_OVH_LEN: ovh_len <= lnk.reg_wdata;
        SR_TRAIN_LO: train[7:0] <= lnk.reg_wdata;
        SR_TRAIN_HI: train[11:8] <= lnk.reg_wdata[3:0];
        SR_PIN_A_SEL: pin_a_sel <= lnk.reg_wdata[2:0];
        SR_PIN_B_SEL: pin_b_sel <= lnk.reg_wdata[2:0];
        SR_OUT_MODE: begin
          outs <= lnk.reg_wdata[OM_OUTS_LSB +: 2];
          wide <= lnk.reg_wdata[OM_WIDE_BIT];
        end
        default: ;
      endcase
    end
  end

  // register reads, answered in the following cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lnk.reg_rdata <= 8'h00;
    end else if (lnk.reg_rd) begin
      case (lnk.reg_addr)
        SR_EXP_SRC: lnk.reg_rdata <= {7'h00, exp_src};
        SR_EXP_LO: lnk.reg_rdata <= exp_len[7:0];
        SR_EXP_HI: lnk.reg_rdata <= exp_len[15:8];
        SR_ROWS_LO: lnk.reg_rdata <= rows[7:0];
        SR_ROWS_HI: lnk.reg_rdata <= rows[15:8];
        SR_OVH_LEN: lnk.reg_rdata <= ovh_len;
        SR_TRAIN_LO: lnk.reg_rdata <= train[7:0];
        SR_TRAIN_HI: lnk.reg_rdata <= {4'h0, train[11:8]};
        SR_PIN_A_SEL: lnk.reg_rdata <= {5'h00, pin_a_sel};
        SR_PIN_B_SEL: lnk.reg_rdata <= {5'h00, pin_b_sel};
        SR_OUT_MODE: lnk.reg_rdata <= {5'h00, wide, outs};
        default: lnk.reg_rdata <= 8'h00;
      endcase
    end
  end

  scc_sync u_start (.sys_clk(sys_clk), .arst_n(arst_n),
    .d(lnk.exposure_start_pin), .q(start_lvl));
  scc_sync u_trig (.sys_clk(sys_clk), .arst_n(arst_n),
    .d(lnk.readout_trigger_pin), .q(trig_lvl));

  assign bit_tick = (bit_cnt == 2'(BIT_CYC - 1));
  assign pix_tick = bit_tick &&
    (bit_idx == (wide_l ? 4'(WORD_WIDE - 1) : 4'(WORD_NARROW - 1)));

  // edges are held until the next word boundary; a new edge beats clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_prev <= 1'b0;
      trig_prev <= 1'b0;
      start_pend <= 1'b0;
      trig_pend <= 1'b0;
    end else begin
      start_prev <= start_lvl;
      trig_prev <= trig_lvl;
      if (start_lvl && !start_prev) begin
        start_pend <= 1'b1;
      end else if (pix_tick) begin
        start_pend <= 1'b0;
      end
      if (trig_lvl && !trig_prev) begin
        trig_pend <= 1'b1;
      end else if (pix_tick) begin
        trig_pend <= 1'b0;
      end
    end
  end

  // bit clock divider; the width change waits for a word boundary
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 2'h0;
      bit_idx <= 4'h0;
      wide_l <= 1'b0;
      lnk.link_clk <= 1'b0;
    end else begin
      bit_cnt <= bit_cnt + 2'h1;
      lnk.link_clk <= (bit_cnt >= 2'h1) && (bit_cnt < 2'h3);
      if (pix_tick) begin
        bit_idx <= 4'h0;
        wide_l <= wide;
      end else if (bit_tick) begin
        bit_idx <= bit_idx + 4'h1;
      end
    end
  end

  // status word for the word about to start
  always_comb begin
    cword = CW_IDLE;
    if (st == ST_READ) begin
      cword[CW_PIX] = (col != 8'h00);
      cword[CW_ROW] = !(col == 8'h00 && burst == 3'h0);
      cword[CW_FRAME] = !(col == 8'h00 && burst == 3'h0 &&
                          row == 16'h0000);
      cword[CW_BURST_OH] = (col == 8'h00);
      cword[CW_LINE_OH] = (col == 8'h00 && burst == 3'h0);
    end
    cword[CW_FOT] = (st == ST_FOT);
    // both groups share one exposure; overhead hides them
    cword[CW_EXP_A] = (st == ST_EXPOSE) && !cword[CW_FOT];
    cword[CW_EXP_B] = (st == ST_EXPOSE) && !cword[CW_FOT];
  end

  // sequencer, steps once per pixel period; no exposure during readout
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_IDLE;
      tcnt <= 32'h0;
      row <= 16'h0000;
      burst <= 3'h0;
      col <= 8'h00;
      frame_busy <= 1'b0;
    end else if (pix_tick) begin
      frame_busy <= (st != ST_IDLE);
      unique case (st)
        ST_IDLE: begin
          if (exp_src && start_pend) begin
            // a trigger in the same word skips ST_EXPOSE and goes straight to overhead
            st <= trig_pend ? ST_FOT : ST_EXPOSE;
            tcnt <= fot_cycles(ovh_len);
          end else if (!exp_src && trig_pend) begin
            st <= ST_EXPOSE;
            tcnt <= 32'(EXP_MULT) * 32'(exp_len);
          end
        end
        ST_EXPOSE: begin
          if (exp_src ? trig_pend : (tcnt <= 32'h1)) begin
            st <= ST_FOT;
            tcnt <= fot_cycles(ovh_len);
          end else begin
            tcnt <= tcnt - 32'h1;
          end
        end
        ST_FOT: begin
          if (tcnt <= 32'h1) begin
            st <= ST_READ;
            row <= 16'h0000;
            burst <= 3'h0;
            col <= 8'h00;
          end else begin
            tcnt <= tcnt - 32'h1;
          end
        end
        ST_READ: begin
          if (col != 8'(BURST_PIX)) begin
            col <= col + 8'h01;
          end else begin
            col <= 8'h00;
            // 16 outs: 1 burst per row, 8: 2, 4: 4, 2: 8
            if (burst == 3'((1 << outs) - 1)) begin
              burst <= 3'h0;
              if (row >= rows - 16'h0001) begin
                st <= ST_IDLE;
              end else begin
                row <= row + 16'h0001;
              end
            end else begin
              burst <= burst + 3'h1;
            end
          end
        end
      endcase
    end
  end

  // serializers, MSB first from bit 11; narrow words sit left-justified
  for (genvar i = 0; i <= DATA_LINES; i++) begin : g_ser
    logic [11:0] word;
    logic [3:0] src;
    always_comb begin
      // duplicate channel data on unused outputs
      src = 4'(i) & ~4'((1 << outs) - 1);
      if (i == DATA_LINES) begin
        word = cword;
      end else if (cword[CW_PIX]) begin
        word = {src, burst[0], 7'(col - 8'h01)};
      end else begin
        word = train;
      end
      if (!wide) begin
        word = {word[9:0], 2'b00};
      end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        sh[i] <= 12'h000;
      end else if (pix_tick) begin
        sh[i] <= word;
      end else if (bit_tick) begin
        sh[i] <= {sh[i][10:0], 1'b0};
      end
    end
    if (i == DATA_LINES) begin : g_ctl
      assign lnk.ctrl_line = sh[i][11];
    end else begin : g_dat
      assign lnk.data_line[i] = sh[i][11];
    end
  end

  // status pins track the word on the line
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lnk.status_pin_a <= 1'b0;
      lnk.status_pin_b <= 1'b0;
    end else if (pix_tick) begin
      lnk.status_pin_a <= sel_bit(pin_a_sel, cword);
      lnk.status_pin_b <= sel_bit(pin_b_sel, cword);
    end
  end
endmodule

// [scc_receiver.sv]
/*
 Receiver end: host register port, sensor register forwarding,
 exposure pin pulses, word alignment on the control line and
 capture of data line 0. Assumes the link clock from the sensor.
*/
`timescale 1ns/1ps
module scc_receiver import scc_pkg::*; (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // async reset, active low
  scc_link_if.receiver lnk, // link to sensor
  input wire logic [3:0] addr, // host register address
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [15:0] rdata // read data, cycle after rd
);
  logic [6:0] sens_addr;
  logic [7:0] rdback;
  logic rd_d;
  logic wide;
  logic [3:0] start_cnt;
  logic [3:0] trig_cnt;
  logic clk_lvl;
  logic clk_prev;
  logic ctl_lvl;
  logic dat_lvl;
  logic [11:0] csh;
  logic [11:0] dsh;
  logic [11:0] next_csh;
  logic [11:0] next_dsh;
  logic [3:0] bcnt;
  logic aligned;
  logic [11:0] ctrl_word;
  logic [15:0] pix_cnt;
  logic [11:0] last_pix;

  scc_sync u_clk (.sys_clk(sys_clk), .arst_n(arst_n),
    .d(lnk.link_clk), .q(clk_lvl));
  scc_sync u_ctl (.sys_clk(sys_clk), .arst_n(arst_n),
    .d(lnk.ctrl_line), .q(ctl_lvl));
  scc_sync u_dat (.sys_clk(sys_clk), .arst_n(arst_n),
    .d(lnk.data_line[0]), .q(dat_lvl));

  assign next_csh = {csh[10:0], ctl_lvl};
  assign next_dsh = {dsh[10:0], dat_lvl};

  // host writes, forwarded sensor accesses and pin pulses
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sens_addr <= 7'h00;
      wide <= 1'b0;
      lnk.reg_addr <= 7'h00;
      lnk.reg_wdata <= 8'h00;
      lnk.reg_wr <= 1'b0;
      lnk.reg_rd <= 1'b0;
      start_cnt <= 4'h0;
      trig_cnt <= 4'h0;
      lnk.exposure_start_pin <= 1'b0;
      lnk.readout_trigger_pin <= 1'b0;
    end else begin
      lnk.reg_wr <= wr && (addr == HR_SENS_WR);
      lnk.reg_rd <= wr && (addr == HR_SENS_RD);
      if (wr && (addr == HR_SENS_ADDR)) begin
        sens_addr <= wdata[6:0];
      end
      if (wr && (addr == HR_SENS_WR || addr == HR_SENS_RD)) begin
        lnk.reg_addr <= sens_addr;
        lnk.reg_wdata <= wdata[7:0];
      end
      if (wr && (addr == HR_CFG)) begin
        wide <= wdata[0];
      end
      // start and trigger may be one cycle apart
      if (wr && (addr == HR_PULSE) && wdata[0]) begin
        start_cnt <= PIN_PULSE_CYC;
      end else if (start_cnt != 4'h0) begin
        start_cnt <= start_cnt - 4'h1;
      end
      if (wr && (addr == HR_PULSE) && wdata[1]) begin
        trig_cnt <= PIN_PULSE_CYC;
      end else if (trig_cnt != 4'h0) begin
        trig_cnt <= trig_cnt - 4'h1;
      end
      lnk.exposure_start_pin <= (start_cnt != 4'h0) ||
        (wr && (addr == HR_PULSE) && wdata[0]);
      lnk.readout_trigger_pin <= (trig_cnt != 4'h0) ||
        (wr && (addr == HR_PULSE) && wdata[1]);
    end
  end

  // sensor read data arrives the cycle after the forwarded read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_d <= 1'b0;
      rdback <= 8'h00;
    end else begin
      rd_d <= lnk.reg_rd;
      if (rd_d) begin
        rdback <= lnk.reg_rdata;
      end
    end
  end

  // deserializer: bits taken on the rising link clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_prev <= 1'b0;
      csh <= 12'h000;
      dsh <= 12'h000;
      bcnt <= 4'h0;
      aligned <= 1'b0;
      ctrl_word <= 12'h000;
      pix_cnt <= 16'h0000;
      last_pix <= 12'h000;
    end else begin
      clk_prev <= clk_lvl;
      if (clk_lvl && !clk_prev) begin
        csh <= next_csh;
        dsh <= next_dsh;
        if (!aligned) begin
          // only the idle word can align; data lines are not used
          if (wide ? (next_csh == CW_IDLE)
                   : (next_csh[9:0] == CW_IDLE[9:0])) begin
            aligned <= 1'b1;
            bcnt <= 4'h0;
          end
        end else if (bcnt == (wide ? 4'(WORD_WIDE - 1)
                                   : 4'(WORD_NARROW - 1))) begin
          bcnt <= 4'h0;
          ctrl_word <= wide ? next_csh : {2'b00, next_csh[9:0]};
          // fixed bits wrong means the boundary slipped
          if (!next_csh[CW_ONE] || next_csh[CW_ONE-1]) begin
            aligned <= 1'b0;
          end
          if (next_csh[CW_PIX]) begin
            pix_cnt <= pix_cnt + 16'h0001;
            last_pix <= wide ? next_dsh : {2'b00, next_dsh[9:0]};
          end
        end else begin
          bcnt <= bcnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        HR_SENS_ADDR: rdata <= {9'h000, sens_addr};
        HR_SENS_RD: rdata <= {8'h00, rdback};
        HR_CFG: rdata <= {15'h0000, wide};
        HR_STATUS: rdata <= {lnk.status_pin_b, lnk.status_pin_a,
                             1'b0, aligned, ctrl_word};
        HR_PIX_CNT: rdata <= pix_cnt;
        HR_LAST_PIX: rdata <= {4'h0, last_pix};
        default: rdata <= 16'h0000;
      endcase
    end
  end
endmodule

// [scc_link_sva.sv]
/*
 Checker for the sensor link: bit clock shape, line change points,
 exposure pin pulses and the sensor register strobes.
 Assumes both ends share sys_clk and arst_n.
*/
`timescale 1ns/1ps
module scc_link_sva (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // async reset
  input wire logic link_clk, // bit clock
  input wire logic ctrl_line, // status line
  input wire logic [15:0] data_line, // data lines
  input wire logic exposure_start_pin, // start pin
  input wire logic readout_trigger_pin, // trigger pin
  input wire logic status_pin_a, // pin a
  input wire logic status_pin_b, // pin b
  input wire logic reg_wr, // reg write
  input wire logic reg_rd, // reg read
  input wire logic [7:0] reg_rdata // reg read data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_LCLK_HIGH: assert property (
    $rose(link_clk) |=> link_clk ##1 !link_clk)
    else $error("bit clock high time wrong");
  AST_LCLK_LOW: assert property (
    $fell(link_clk) |=> !link_clk ##1 link_clk)
    else $error("bit clock low time wrong");
  // receiver samples on the rise, so lines may move only while low
  AST_CTRL_EDGE: assert property (!$stable(ctrl_line) |-> !link_clk)
    else $error("status line moved with clock high");
  AST_DATA_EDGE: assert property (!$stable(data_line) |-> !link_clk)
    else $error("data lines moved with clock high");
  AST_PINS_EDGE: assert property (!$stable({status_pin_a, status_pin_b})
    |-> !link_clk)
    else $error("status pins moved inside a bit");
  AST_START_LEN: assert property ($rose(exposure_start_pin)
    |=> exposure_start_pin[*8] ##1 !exposure_start_pin)
    else $error("start pulse length wrong");
  AST_TRIG_LEN: assert property ($rose(readout_trigger_pin)
    |=> readout_trigger_pin[*8] ##1 !readout_trigger_pin)
    else $error("trigger pulse length wrong");
  AST_REG_STROBE: assert property (reg_rd |-> !reg_wr ##1 !reg_rd)
    else $error("register strobes overlap or stretch");
  AST_RDATA_HOLD: assert property (!$stable(reg_rdata) |-> $past(reg_rd))
    else $error("register read data moved without read");
  cover property ($rose(exposure_start_pin));
  cover property ($rose(readout_trigger_pin));
  cover property ($rose(status_pin_a));
endmodule

// [testbench.sv]
/*
 Testbench: sensor and receiver ends joined by the link interface,
 driven through the receiver's host register port.
 Assumes the receiver's host register map and pin pulse timing.
*/
`timescale 1ns/1ps
module testbench import scc_pkg::*;;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic frame_busy;
  logic [15:0] v;
  int n_errors = 0;
  int checks = 0;
  logic [6:0] ra [7] = '{SR_EXP_SRC, SR_EXP_LO, SR_EXP_HI, SR_TRAIN_LO,
    SR_TRAIN_HI, SR_PIN_A_SEL, SR_PIN_B_SEL};
  logic [15:0] rv [7] = '{16'h0000, 16'h0000, 16'h0008, 16'h00a5,
    16'h0003, 16'h0000, 16'h0000};
  scc_link_if lnk();
  scc_sensor u_scc_sensor(.sys_clk(sys_clk), .arst_n(arst_n), .lnk(lnk),
    .frame_busy(frame_busy));
  scc_receiver u_scc_receiver(.sys_clk(sys_clk), .arst_n(arst_n),
    .lnk(lnk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  scc_link_sva u_scc_link_sva(.sys_clk(sys_clk), .arst_n(arst_n),
    .link_clk(lnk.link_clk), .ctrl_line(lnk.ctrl_line),
    .data_line(lnk.data_line), .exposure_start_pin(lnk.exposure_start_pin),
    .readout_trigger_pin(lnk.readout_trigger_pin),
    .status_pin_a(lnk.status_pin_a), .status_pin_b(lnk.status_pin_b),
    .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_rdata(lnk.reg_rdata));
  always #50 sys_clk = ~sys_clk;
  task complete_run;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input string name, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask
  task hw(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task hr(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    d = rdata;
  endtask
  task sw(input logic [6:0] a, input logic [7:0] d);
    hw(HR_SENS_ADDR, {9'h000, a});
    hw(HR_SENS_WR, {8'h00, d});
  endtask
  task sr(input logic [6:0] a, output logic [15:0] d);
    hw(HR_SENS_ADDR, {9'h000, a});
    hw(HR_SENS_RD, 16'h0000);
    repeat (3) @(posedge sys_clk);
    hr(HR_SENS_RD, d);
  endtask
  // readout ends with frame_busy low; bounded so a hang still reports
  task wait_idle;
    int i;
    for (i = 0; i < 30000 && frame_busy !== 1'b0; i++) @(posedge sys_clk);
    if (frame_busy !== 1'b0) begin
      n_errors++;
      $display("Error frame_busy expected 0 seen %b", frame_busy);
      complete_run;
    end else begin
      // the last word is still in the receiver's sampler
      repeat (2 * BIT_CYC * WORD_WIDE) @(posedge sys_clk);
    end
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (400) @(posedge sys_clk);
    hr(HR_STATUS, v);
    chk("idle status", 16'h1200, v);
    for (int k = 0; k < 7; k++) begin
      sr(ra[k], v);
      chk("sensor reg reset", rv[k], v);
    end
    sr(7'h7f, v);
    chk("unmapped sensor reg", 16'h0000, v);
    hr(4'hf, v);
    chk("unmapped host reg", 16'h0000, v);
    sr(SR_OVH_LEN, v);
    chk("overhead length reset", {8'h00, OVH_LEN_RST}, v);
    sw(SR_TRAIN_LO, 8'h5c);
    sw(SR_TRAIN_HI, 8'h0a);
    sr(SR_TRAIN_LO, v);
    chk("training low", 16'h005c, v);
    sr(SR_TRAIN_HI, v);
    chk("training high", 16'h000a, v);
    $display("test registers done");
    // shortened frame: two rows, unit exposure and overhead
    sw(SR_ROWS_LO, 8'h02);
    sw(SR_ROWS_HI, 8'h00);
    sw(SR_EXP_LO, 8'h01);
    sw(SR_EXP_HI, 8'h00);
    sw(SR_OVH_LEN, 8'h01);
    sw(SR_PIN_B_SEL, 8'h04);
    sr(SR_PIN_B_SEL, v);
    chk("pin b select", 16'h0004, v);
    hw(HR_PULSE, 16'h0002);
    repeat (2000) @(posedge sys_clk);
    hr(HR_STATUS, v);
    chk("status exposing", 16'h52c0, v);
    repeat (4300) @(posedge sys_clk);
    hr(HR_STATUS, v);
    chk("status overhead", 16'h1220, v);
    wait_idle;
    hr(HR_PIX_CNT, v);
    chk("pixel count", 16'h0100, v);
    hr(HR_LAST_PIX, v);
    chk("last pixel", 16'h007f, v);
    hr(HR_STATUS, v);
    chk("status after frame", 16'h1200, v);
    $display("test internal exposure done");
    sw(SR_EXP_SRC, 8'h01);
    hw(HR_PULSE, 16'h0001);
    repeat (2000) @(posedge sys_clk);
    hr(HR_STATUS, v);
    chk("status ext exposing", 16'h52c0, v);
    hw(HR_PULSE, 16'h0002);
    repeat (200) @(posedge sys_clk);
    wait_idle;
    hr(HR_PIX_CNT, v);
    chk("pixel count ext", 16'h0200, v);
    $display("test external exposure done");
    // eight outputs: two bursts per row, start and trigger close together
    sw(SR_OUT_MODE, 8'h01);
    hw(HR_PULSE, 16'h0001);
    hw(HR_PULSE, 16'h0002);
    repeat (200) @(posedge sys_clk);
    wait_idle;
    hr(HR_PIX_CNT, v);
    chk("pixel count 8 outs", 16'h0400, v);
    hr(HR_LAST_PIX, v);
    chk("last pixel 8 outs", 16'h00ff, v);
    $display("test eight outputs done");
    sw(SR_OUT_MODE, 8'h04);
    hw(HR_CFG, 16'h0001);
    repeat (1000) @(posedge sys_clk);
    hr(HR_STATUS, v);
    chk("status wide idle", 16'h1200, v);
    $display("test wide word done");
    complete_run;
  end
endmodule
